/* File: bcd_counter_pkg.sv */
package bcd_counter_pkg;

    // Core clock period, in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 4000;

    // Interdigit blanking, least figure of the typical range
    localparam int unsigned GAP_NS  = 3000;
    localparam logic [15:0] GAP_CYC =
        16'((GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Load request setup before a digit strobe rises
    localparam int unsigned LOAD_SETUP_NS  = 2000;
    localparam logic [9:0]  LOAD_SETUP_CYC =
        10'((LOAD_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    // Internal scan oscillator nominal rate
    localparam int unsigned SCAN_HZ         = 5000;
    localparam int unsigned SCAN_PERIOD_DEF = 1000000000 / (CLK_PERIOD_PS / 1000) / SCAN_HZ;

    // Decade count and Johnson codes
    localparam int unsigned NUM_DIGITS = 6;
    localparam logic [2:0]  JOHN_MSD   = 3'h0;
    localparam logic [5:0]  STROBE_RST = 6'h20;

    // Register offsets (byte addresses)
    localparam logic [11:0] OFS_CTRL   = 12'h000;
    localparam logic [11:0] OFS_COUNT  = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    // Control field positions and reset values
    localparam int unsigned CTRL_SCAN_EXT_BIT = 0;
    localparam logic        CTRL_SCAN_EXT_RST = 1'b0;

    // Status field positions
    localparam int unsigned ST_LOAD_BIT  = 0;
    localparam int unsigned ST_CARRY_BIT = 1;
    localparam int unsigned ST_ZERO_BIT  = 2;
    localparam int unsigned ST_IDX_LSB   = 4;

    typedef enum logic [1:0] {
        SCAN_SHOW      = 2'b00,
        SCAN_WAIT_HIGH = 2'b01,
        SCAN_GAP       = 2'b10
    } scan_state_t;

endpackage : bcd_counter_pkg

/* File: bcd_decade_step.sv */
`timescale 1ns/100ps
// One BCD decade: next value and ripple of the look-ahead carry
module bcd_decade_step (
    input  wire logic [3:0] digit,   // Present decade value
    input  wire logic       up,      // High counts up
    input  wire logic       en,      // Step this decade
    output logic      [3:0] nxt,     // Value after the step
    output logic            co       // Carry or borrow out
);
    // Wrap 9 to 0 going up, 0 to 9 going down
    always_comb begin
        co  = en & (up ? (digit == 4'h9) : (digit == 4'h0));
        nxt = digit;
        if (en) begin
            if (up) begin
                nxt = (digit == 4'h9) ? 4'h0 : 4'(digit + 4'h1);
            end else begin
                nxt = (digit == 4'h0) ? 4'h9 : 4'(digit - 4'h1);
            end
        end
    end
endmodule : bcd_decade_step

/* File: seg7_decode.sv */
`timescale 1ns/100ps
// Numeral to segment pattern, bit 0 is segment a
module seg7_decode (
    input  wire logic [3:0] bcd,     // Digit value
    output logic      [6:0] seg      // Segments g..a, high lit
);
    // Codes above 9 stay dark rather than show junk
    always_comb begin
        unique case (bcd)
            4'h0:    seg = 7'h3F;
            4'h1:    seg = 7'h06;
            4'h2:    seg = 7'h5B;
            4'h3:    seg = 7'h4F;
            4'h4:    seg = 7'h66;
            4'h5:    seg = 7'h6D;
            4'h6:    seg = 7'h7D;
            4'h7:    seg = 7'h07;
            4'h8:    seg = 7'h7F;
            4'h9:    seg = 7'h6F;
            default: seg = 7'h00;
        endcase
    end
endmodule : seg7_decode

/* File: bcd_counter_display.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
// Contract
// - All six decades step together per count rise
// - Direction high counts up, low down
// - Inhibit high through pulse leaves counter unchanged
// - Clear zeroes counter only, not latch or scan
// - Store low follows counter, high holds latch
// - Load request captured at target digit strobe rise
// - Zero flag one count period, suppressed during load
// - Carry rises at rollover, falls with count low
// - Carry suppressed while a load is active
// - Johnson divide-by-six scan, most to least significant
// - Scan home holds MOST_SIGNIFICANT_DIGIT, blanks segments, shows BCD
// - After home, digit 6 stays until next scan
// - Segments and strobes blanked in interdigit gap
// - BCD output changes at start of gap
// - External scan low dwell lengthens the gap
// - All outputs active high
// - Load suppression ends only if release early in gap
module bcd_counter_display #(
    parameter bit          SEG_VARIANT     = 1'b1,   // 1 segments, 0 BCD with zero flag
    parameter int unsigned SCAN_PERIOD_CYC = bcd_counter_pkg::SCAN_PERIOD_DEF
) (
    input  wire logic        core_clk,        // 250 MHz clock
    input  wire logic        reset_n,         // Asynchronous reset
    input  wire logic        count_in,        // Count input
    input  wire logic        count_up,        // Direction, high up
    input  wire logic        count_inhibit,   // Inhibit counting
    input  wire logic        counter_clear,   // Clear counter
    input  wire logic        store,           // High holds display latch
    input  wire logic        load_req,        // Load counter request
    input  wire logic [3:0]  bcd_in,          // Load data
    input  wire logic        scan_in,         // External scan drive
    input  wire logic        scan_home_n,     // Low forces scan home
    output logic      [5:0]  digit_strobe,    // Bit 5 is the MOST_SIGNIFICANT_DIGIT strobe
    output logic      [3:0]  bcd_out,         // Scanned digit value
    output logic      [6:0]  seg_out,         // Segments g..a
    output logic             carry_out,       // Carry or borrow flag
    output logic             zero_out,        // All-zero flag
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB enable
    input  wire logic        pwrite,          // APB direction
    input  wire logic [11:0] paddr,           // APB address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr          // APB error
);
    localparam int unsigned ND = bcd_counter_pkg::NUM_DIGITS;

    // Words below are laid out for six decades
    if (ND != 6) begin : g_bad_digits
        $error("NUM_DIGITS must be 6");
    end

    // Counter must exceed the gap plus room to show a digit
    if (SCAN_PERIOD_CYC <= 32'(bcd_counter_pkg::GAP_CYC) + 2 ||
        SCAN_PERIOD_CYC >= (1 << 20)) begin : g_bad_period
        $error("SCAN_PERIOD_CYC out of range");
    end

    // Johnson code to digit position, 5 is the MOST_SIGNIFICANT_DIGIT
    function automatic logic [2:0] john_idx(input logic [2:0] j);
        unique case (j)
            3'b000:  john_idx = 3'd5;
            3'b001:  john_idx = 3'd4;
            3'b011:  john_idx = 3'd3;
            3'b111:  john_idx = 3'd2;
            3'b110:  john_idx = 3'd1;
            3'b100:  john_idx = 3'd0;
            default: john_idx = 3'd5;
        endcase
    endfunction : john_idx

    // All block state, registered as one word
    typedef struct packed {
        logic [23:0]                  cnt;
        logic [23:0]                  latch;
        logic                         cnt_prev;
        logic                         scan_prev;
        logic [2:0]                   john;
        bcd_counter_pkg::scan_state_t sstate;
        logic [15:0]                  gap_cnt;
        logic [19:0]                  tick_cnt;
        logic [3:0]                   bcd;
        logic [6:0]                   seg;
        logic [5:0]                   strobe;
        logic                         carry;
        logic                         zero;
        logic                         load_active;
        logic                         load_pend;
        logic                         load_prev;
        logic [9:0]                   low_cnt;
        logic                         fell_in_gap;
        logic                         scan_ext;
        logic                         pready;
        logic                         pslverr;
        logic [31:0]                  prdata;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    // Ripple of decade steppers, each sees the carry of the one below
    logic [ND-1:0]   dec_en;
    logic [ND-1:0]   dec_co;
    logic [23:0]     cnt_step;
    logic            count_rise;
    logic            count_step;
    logic [6:0]      seg_dec;
    logic [3:0]      dec_bcd;

    // Rises need a low sample between them
    assign count_rise = count_in & ~st_ff.cnt_prev;
    assign count_step = count_rise & ~count_inhibit;

    // Look-ahead carry: all decades move on one edge
    genvar gi;
    generate
        for (gi = 0; gi < ND; gi++) begin : g_dec
            if (gi == 0) begin : g_first
                assign dec_en[gi] = count_step;
            end else begin : g_rest
                assign dec_en[gi] = dec_co[gi-1];
            end
            bcd_decade_step u_step (
                .digit (st_ff.cnt[gi*4 +: 4]),
                .up    (count_up),
                .en    (dec_en[gi]),
                .nxt   (cnt_step[gi*4 +: 4]),
                .co    (dec_co[gi])
            );
        end
    endgenerate

    // Decodes next value, so segments track strobes
    seg7_decode u_seg (
        .bcd (dec_bcd),
        .seg (seg_dec)
    );

    // Next state of counter, scan, flags and register file
    always_comb begin
        logic       scan_step;
        logic       strobe_rise;
        logic       in_gap;
        logic [2:0] idx;
        logic [2:0] nidx;
        nxt_st      = st_ff;
        scan_step   = 1'b0;
        strobe_rise = 1'b0;
        in_gap      = (st_ff.sstate != bcd_counter_pkg::SCAN_SHOW);
        idx         = john_idx(st_ff.john);
        nidx        = idx;
        dec_bcd     = st_ff.bcd;

        // Previous samples for edge detection
        nxt_st.cnt_prev  = count_in;
        nxt_st.scan_prev = scan_in;
        nxt_st.load_prev = load_req;

        // Scan clock: internal divider or external falling edge
        if (st_ff.scan_ext) begin
            nxt_st.tick_cnt = 20'h00000;
            scan_step = st_ff.scan_prev & ~scan_in;
        end else if (st_ff.tick_cnt >= 20'(SCAN_PERIOD_CYC - 1)) begin
            nxt_st.tick_cnt = 20'h00000;
            scan_step = 1'b1;
        end else begin
            nxt_st.tick_cnt = st_ff.tick_cnt + 20'h00001;
        end

        // Scan sequencing with blanking gap
        if (!scan_home_n) begin
            // Home beats any step, so the top digit holds
            nxt_st.john    = bcd_counter_pkg::JOHN_MSD;
            nxt_st.sstate  = bcd_counter_pkg::SCAN_SHOW;
            nxt_st.gap_cnt = 16'h0000;
            scan_step      = 1'b0;
        end else begin
            unique case (st_ff.sstate)
                bcd_counter_pkg::SCAN_SHOW: begin
                    // Digit stays lit until the next scan clock
                    if (scan_step) begin
                        nxt_st.john    = {st_ff.john[1:0], ~st_ff.john[2]};
                        nxt_st.gap_cnt = bcd_counter_pkg::GAP_CYC;
                        nxt_st.sstate  = st_ff.scan_ext ? bcd_counter_pkg::SCAN_WAIT_HIGH
                                                        : bcd_counter_pkg::SCAN_GAP;
                    end
                end
                bcd_counter_pkg::SCAN_WAIT_HIGH: begin
                    // Low dwell of external drive adds to the gap
                    if (scan_in) begin
                        nxt_st.sstate = bcd_counter_pkg::SCAN_GAP;
                    end
                end
                bcd_counter_pkg::SCAN_GAP: begin
                    if (st_ff.gap_cnt <= 16'h0001) begin
                        nxt_st.gap_cnt = 16'h0000;
                        nxt_st.sstate  = bcd_counter_pkg::SCAN_SHOW;
                        strobe_rise    = 1'b1;
                    end else begin
                        nxt_st.gap_cnt = st_ff.gap_cnt - 16'h0001;
                    end
                end
                default: begin
                    nxt_st.sstate = bcd_counter_pkg::SCAN_SHOW;
                end
            endcase
        end
        // Digit that is lit after this edge
        nidx = john_idx(nxt_st.john);

        // Load: request caught at strobe rise, data taken at strobe fall
        if (strobe_rise) begin
            nxt_st.load_pend = load_req;
        end
        if (scan_step) begin
            nxt_st.load_pend = 1'b0;
        end

        // Release counted only if it fell inside a gap
        if (load_req) begin
            nxt_st.low_cnt = 10'h000;
        end else if (st_ff.low_cnt < bcd_counter_pkg::LOAD_SETUP_CYC) begin
            nxt_st.low_cnt = st_ff.low_cnt + 10'h001;
        end
        if (st_ff.load_prev && !load_req) begin
            nxt_st.fell_in_gap = in_gap;
        end
        if (strobe_rise && !load_req && st_ff.fell_in_gap &&
            st_ff.low_cnt >= bcd_counter_pkg::LOAD_SETUP_CYC) begin
            nxt_st.load_active = 1'b0;
        end
        // A new request re-arms flag suppression
        if (load_req) begin
            nxt_st.load_active = 1'b1; // Set wins over release
        end

        // Clear is clocked like any input, so it acts at the edge that samples it
        // Counter: clear beats load beats count
        if (counter_clear) begin
            nxt_st.cnt = 24'h000000;
        end else if (scan_step && st_ff.load_pend) begin
            nxt_st.cnt[idx*4 +: 4] = bcd_in;
        end else begin
            nxt_st.cnt = cnt_step;
        end

        // Zero flag refreshed on every count rise
        if (count_rise) begin
            nxt_st.zero = (nxt_st.cnt == 24'h000000) & ~nxt_st.load_active
                          & ~SEG_VARIANT;
        end

        // Carry: rises at rollover, falls with the count input
        if (count_step && dec_co[ND-1] && !counter_clear) begin
            nxt_st.carry = 1'b1;
        end else if (!count_in) begin
            nxt_st.carry = 1'b0;
        end
        if (nxt_st.load_active) begin
            nxt_st.carry = 1'b0;
        end

        // Display latch follows the counter while store is low
        if (!store) begin
            nxt_st.latch = nxt_st.cnt;
        end

        // Value changes as the gap opens, so it is settled at strobe rise
        if (!scan_home_n || scan_step) begin
            nxt_st.bcd = nxt_st.latch[nidx*4 +: 4];
        end
        dec_bcd = nxt_st.bcd;

        // Strobes and segments dark in the gap and, for segments, at home
        nxt_st.strobe = 6'h00;
        nxt_st.seg    = 7'h00;
        if (nxt_st.sstate == bcd_counter_pkg::SCAN_SHOW) begin
            nxt_st.strobe[nidx] = 1'b1;
            if (scan_home_n && SEG_VARIANT) begin
                nxt_st.seg = seg_dec;
            end
        end

        // APB slave: data prepared in setup, ready in the access cycle
        nxt_st.pready  = psel & ~penable;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = 32'h00000000;
        if (psel && !penable) begin
            unique case (paddr)
                bcd_counter_pkg::OFS_CTRL: begin
                    nxt_st.prdata[bcd_counter_pkg::CTRL_SCAN_EXT_BIT] = st_ff.scan_ext;
                end
                bcd_counter_pkg::OFS_COUNT: begin
                    nxt_st.prdata[23:0] = st_ff.cnt;
                end
                bcd_counter_pkg::OFS_STATUS: begin
                    nxt_st.prdata[bcd_counter_pkg::ST_LOAD_BIT]  = st_ff.load_active;
                    nxt_st.prdata[bcd_counter_pkg::ST_CARRY_BIT] = st_ff.carry;
                    nxt_st.prdata[bcd_counter_pkg::ST_ZERO_BIT]  = st_ff.zero;
                    nxt_st.prdata[bcd_counter_pkg::ST_IDX_LSB +: 3] = idx;
                end
                default: begin
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end
        // Write lands at the access edge only
        if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr &&
            paddr == bcd_counter_pkg::OFS_CTRL) begin
            nxt_st.scan_ext = pwdata[bcd_counter_pkg::CTRL_SCAN_EXT_BIT];
        end
    end

    // Single state register; reset leaves scan at the MOST_SIGNIFICANT_DIGIT
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff          <= '0;
            st_ff.john     <= bcd_counter_pkg::JOHN_MSD;
            st_ff.sstate   <= bcd_counter_pkg::SCAN_SHOW;
            st_ff.strobe   <= bcd_counter_pkg::STROBE_RST;
            st_ff.scan_ext <= bcd_counter_pkg::CTRL_SCAN_EXT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Pins straight from flops, free of decode glitches
    assign digit_strobe = st_ff.strobe;
    assign bcd_out      = st_ff.bcd;
    assign seg_out      = st_ff.seg;
    assign carry_out    = st_ff.carry;
    assign zero_out     = st_ff.zero;
    assign prdata       = st_ff.prdata;
    assign pready       = st_ff.pready;
    assign pslverr      = st_ff.pslverr;

endmodule : bcd_counter_display

/* File: bcd_display_props.sv */
`timescale 1ns/100ps
module bcd_display_props #(
    parameter bit SEG_VARIANT = 1'b1      // Output variant under check
) (
    input wire logic       core_clk,      // Core clock
    input wire logic       reset_n,       // Asynchronous reset
    input wire logic       count_in,      // Count input
    input wire logic       count_inhibit, // Inhibit counting
    input wire logic       counter_clear, // Clear counter
    input wire logic       scan_home_n,   // Scan home, active low
    input wire logic [5:0] digit_strobe,  // Digit strobes
    input wire logic [3:0] bcd_out,       // Scanned digit value
    input wire logic [6:0] seg_out,       // Segments
    input wire logic       carry_out,     // Carry flag
    input wire logic       zero_out       // Zero flag
);
    typedef struct packed {
        logic [5:0]  last;
        logic [15:0] gap;
    } mon_t;
    mon_t mon_ff, nxt_mon;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Last lit digit and length of the present dark spell
    always_comb begin
        nxt_mon = mon_ff;
        if (digit_strobe != 6'h00) nxt_mon.last = digit_strobe;
        nxt_mon.gap = (digit_strobe == 6'h00) ? mon_ff.gap + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) mon_ff <= '0;
        else mon_ff <= nxt_mon;
    end

    // Steps of a count and of a digit period
    sequence rise_seen;
        $past(count_in) && !$past(count_in, 2);
    endsequence
    sequence strobe_on;
        digit_strobe != 6'h00 && $past(digit_strobe) == 6'h00 && $past(scan_home_n);
    endsequence

    a_strobe_onehot: assert property ($onehot0(digit_strobe))
        else $error("strobes not one-hot");
    a_strobe_order: assert property (strobe_on ##0 (scan_home_n && mon_ff.last != 6'h00)
        |-> digit_strobe == ((mon_ff.last == 6'h01) ? 6'h20 : mon_ff.last >> 1))
        else $error("digit order broken");
    a_gap_length: assert property (strobe_on |-> mon_ff.gap >= bcd_counter_pkg::GAP_CYC)
        else $error("interdigit gap too short");
    a_gap_blank: assert property (digit_strobe == 6'h00 |-> seg_out == 7'h00)
        else $error("segments lit in gap");
    a_home_blank: assert property (!scan_home_n && $past(scan_home_n) == 1'b0
        |-> seg_out == 7'h00 && digit_strobe == 6'h20) else $error("home not held");
    a_bcd_stable: assert property (digit_strobe != 6'h00 && $past(digit_strobe) != 6'h00
        && scan_home_n && $past(scan_home_n) |-> $stable(bcd_out)) else $error("bcd moved");
    a_carry_drop: assert property (!count_in |=> !carry_out)
        else $error("carry outlived count pulse");
    a_carry_cause: assert property ($rose(carry_out) |-> rise_seen
        ##0 (!$past(count_inhibit) && !$past(counter_clear))) else $error("stray carry");
    a_zero_cause: assert property ($changed(zero_out) |-> rise_seen)
        else $error("zero flag moved without count");
    a_zero_variant: assert property (!SEG_VARIANT || !zero_out)
        else $error("zero flag in segment variant");
    a_seg_variant: assert property (SEG_VARIANT || seg_out == 7'h00)
        else $error("segments in bcd variant");
endmodule : bcd_display_props

bind bcd_counter_display bcd_display_props #(.SEG_VARIANT(SEG_VARIANT)) i_bcd_display_props (
    .core_clk, .reset_n, .count_in, .count_inhibit, .counter_clear, .scan_home_n,
    .digit_strobe, .bcd_out, .seg_out, .carry_out, .zero_out
);

/* File: thumbwheel_bank.sv */
`timescale 1ns/100ps
module thumbwheel_bank (
    input  wire logic [5:0]  digit_strobe, // Strobes from the counter
    input  wire logic [23:0] sw_val,       // Switch settings, nibble 0 least significant
    output logic      [3:0]  bcd_in        // Data lines to the counter
);
    // Diode per line: pulled down unless a strobed switch drives it
    always_comb begin
        bcd_in = 4'h0;
        for (int k = 0; k < 6; k++) begin
            if (digit_strobe[k]) begin
                bcd_in = bcd_in | sw_val[4*k +: 4]; // Held until strobe falls
            end
        end
    end
endmodule : thumbwheel_bank

/* File: six_decade_bcd_counter_display_scan_test.sv */
`timescale 1ns/100ps
module six_decade_bcd_counter_display_scan_test;
    localparam int SP = 800;   // Short scan period keeps the run brief
    localparam logic [6:0] SEG_TBL [10] =
        '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
    logic        core_clk, reset_n, count_in, count_up, count_inhibit, counter_clear;
    logic        store, load_req, scan_in, scan_home_n, psel, penable, pwrite;
    logic        pready, pslverr, carry_out, zero_out, cy, er, zero_bcd;
    logic [3:0]  bcd_in, bcd_out;
    logic [5:0]  digit_strobe;
    logic [6:0]  seg_out, seg_bcd;
    logic [11:0] paddr;
    logic [23:0] sw_val;
    logic [31:0] pwdata, prdata, rd;
    int          miscompares, total_checks;

    bcd_counter_display #(.SEG_VARIANT(1'b1), .SCAN_PERIOD_CYC(SP)) i_bcd_counter_display (
        .core_clk, .reset_n, .count_in, .count_up, .count_inhibit, .counter_clear, .store,
        .load_req, .bcd_in, .scan_in, .scan_home_n, .digit_strobe, .bcd_out, .seg_out,
        .carry_out, .zero_out, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr
    );
    thumbwheel_bank i_thumbwheel_bank (.digit_strobe, .sw_val, .bcd_in);
    // BCD variant twin on the same stimulus, for the zero flag
    bcd_counter_display #(.SEG_VARIANT(1'b0), .SCAN_PERIOD_CYC(SP)) i_bcd_counter_display_bcd (
        .core_clk, .reset_n, .count_in, .count_up, .count_inhibit, .counter_clear, .store,
        .load_req, .bcd_in, .scan_in, .scan_home_n, .digit_strobe(), .bcd_out(),
        .seg_out(seg_bcd), .carry_out(), .zero_out(zero_bcd), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata(), .pready(), .pslverr()
    );

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Setup then access, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd & m, exp);
    endtask : rdc

    // Slow pulses so the flags can follow the count
    task automatic pulse(input logic up, input logic inh, output logic c);
        count_up      <= up;
        count_inhibit <= inh;
        count_in      <= 1'b1;
        tick(2);
        c = carry_out;
        count_in      <= 1'b0;
        count_inhibit <= 1'b0;
        tick(200);
        chk(carry_out, 32'h0);
    endtask : pulse

    // Wait until the strobes equal, or differ from, a pattern
    task automatic wt(input logic [5:0] s, input bit eq);
        int n;
        n = 0;
        while ((digit_strobe === s) != eq && n < 6000) begin
            @(posedge core_clk);
            n++;
        end
        chk(n < 6000, 32'h1);
    endtask : wt

    task automatic scan_chk(input logic [23:0] v);
        wt(6'h00, 1'b1);
        for (int k = 5; k >= 0; k--) begin
            wt(6'h01 << k, 1'b1);
            chk(bcd_out, v[4*k +: 4]);
            chk({seg_bcd, seg_out}, {7'h00, SEG_TBL[v[4*k +: 4]]});
        end
    endtask : scan_chk

    // Whole-counter load, released in a gap or while a digit is lit
    task automatic ld(input logic [23:0] v, input bit in_gap, input logic act);
        logic c;
        sw_val   <= v;
        load_req <= 1'b1;
        tick(1);
        pulse(1'b0, 1'b0, c);
        chk(c, 32'h0);
        tick(7 * SP);
        rdc(bcd_counter_pkg::OFS_STATUS, 32'h1, 32'h1);
        wt(6'h00, ~in_gap);
        wt(6'h00, in_gap);
        load_req <= 1'b0;
        tick(2 * SP);
        rdc(bcd_counter_pkg::OFS_STATUS, 32'h1, {31'h0, act});
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFF, {8'h00, v});
    endtask : ld

    // Main sequence
    initial begin
        int n;
        reset_n = 1'b0;
        {count_in, count_inhibit, counter_clear, store, load_req} = 5'h00;
        {psel, penable, pwrite, count_up, scan_in, scan_home_n} = 6'h07;
        paddr = 12'h000;
        pwdata = 32'h0;
        sw_val = 24'h000000;
        miscompares = 0;
        total_checks = 0;
        tick(10);
        chk(digit_strobe, 32'h20);
        reset_n <= 1'b1;
        tick(1);
        rdc(bcd_counter_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, bcd_counter_pkg::OFS_COUNT, 32'h00000123);
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFFFF, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        pulse(1'b0, 1'b0, cy);
        chk(cy, 32'h1);
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFF, 32'h999999);
        pulse(1'b1, 1'b0, cy);
        chk(cy, 32'h1);
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFF, 32'h0);
        chk({zero_bcd, zero_out}, 32'h2);
        pulse(1'b1, 1'b0, cy);
        chk(cy, 32'h0);
        chk(zero_bcd, 32'h0);
        pulse(1'b1, 1'b1, cy);
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFF, 32'h1);
        store <= 1'b1;
        counter_clear <= 1'b1;
        tick(2);
        counter_clear <= 1'b0;
        rdc(bcd_counter_pkg::OFS_COUNT, 32'hFFFFFF, 32'h0);
        scan_chk(24'h000001);
        store <= 1'b0;
        scan_chk(24'h000000);
        ld(24'h012345, 1'b1, 1'b0);
        scan_chk(24'h012345);
        ld(24'h678999, 1'b0, 1'b1);
        wt(6'h00, 1'b0);
        wt(6'h00, 1'b1);
        load_req <= 1'b1;
        tick(1);
        load_req <= 1'b0;
        tick(2 * SP);
        rdc(bcd_counter_pkg::OFS_STATUS, 32'h1, 32'h0);
        scan_chk(24'h678999);
        scan_home_n <= 1'b0;
        tick(20);
        chk({digit_strobe, seg_out, bcd_out}, {6'h20, 7'h00, 4'h6});
        scan_home_n <= 1'b1;
        wt(6'h00, 1'b1);
        wt(6'h00, 1'b0);
        chk(digit_strobe, 32'h10);
        apb(1'b1, bcd_counter_pkg::OFS_CTRL, 32'h1);
        rdc(bcd_counter_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h1);
        scan_in <= 1'b0;
        tick(200);
        scan_in <= 1'b1;
        n = 200;
        while (digit_strobe === 6'h00 && n < 5000) begin
            @(posedge core_clk);
            n++;
        end
        chk(n >= 950 && n <= 960, 32'h1);
        apb(1'b1, bcd_counter_pkg::OFS_CTRL, 32'h0);
        final_report();
    end

    // Hang guard, about twice the expected run
    initial begin
        tick(100000);
        miscompares++;
        final_report();
    end
endmodule : six_decade_bcd_counter_display_scan_test
